// *** shared/spwm_pkg.sv ***
// constants, types and reset values for the switching-supply control block
// assumes a 10 MHz system clock and analog comparator results arriving as pins
// Contract
// - below turn-on, startup cell charges; above, bias on
// - below turn-off: bias off, soft count cleared
// - turn-off shutdown only after operation was entered
// - auto restart disables bias, recovers without power cycle
// - burst mode: bias mostly off, reference kept on
// - sensed ramp above feedback resets the latch
// - ramp reset closed in off interval, opens at trigger
// - gate held off about 156ns after trigger
// - summed sense ramp feeds PWM and soft comparators
// - soft start begins on crossing turn-on threshold
// - soft step every 600us, 32 steps
// - soft start ends at 20ms, sink switched off
// - soft start rerun at every auto restart attempt
// - 65KHz nominal, swept 2.6KHz over 4ms
// - jitter only in normal operation after soft start
// - maximum duty 0.75, gate off for remainder
// - latch set each cycle, three comparators reset it
// - gate forced low during undervoltage lockout
package spwm_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned OSC_HZ = 65_000;
   localparam int unsigned JIT_HZ = 2_600;
   localparam int unsigned JIT_PERIOD_MS = 4;
   localparam int unsigned MIN_OFF_NS = 156;
   localparam int unsigned SOFT_STEP_US = 600;
   localparam int unsigned SOFT_DONE_MS = 20;
   localparam int unsigned SOFT_STEPS = 32;
   localparam int unsigned DUTY_NUM = 3;
   localparam int unsigned DUTY_DEN = 4;

   localparam int unsigned OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
   localparam int unsigned JIT_DEV_CYC = OSC_PERIOD_CYC * JIT_HZ / OSC_HZ;
   localparam int unsigned JIT_PERIOD_CYC = CLK_HZ / 1000 * JIT_PERIOD_MS;
   localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SOFT_STEP_CYC = SOFT_STEP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SOFT_DONE_CYC = SOFT_DONE_MS * (CLK_HZ / 1000);

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] PER_OFS = 8'h08;
   localparam int unsigned CTRL_GATE_BIT = 0;
   localparam int unsigned CTRL_JIT_BIT = 1;
   localparam logic CTRL_GATE_RST = 1'h1;
   localparam logic CTRL_JIT_RST = 1'h1;
   localparam int unsigned ST_MODE_LSB = 0;
   localparam int unsigned ST_STEP_LSB = 5;
   localparam int unsigned ST_LATCH_BIT = 10;
   localparam int unsigned ST_GATE_BIT = 11;
   localparam int unsigned ST_BIAS_BIT = 12;
   localparam int unsigned ST_START_BIT = 13;
   localparam int unsigned ST_JIT_BIT = 14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      MODE_LOCKOUT = 5'h01,
      MODE_SOFT = 5'h02,
      MODE_NORMAL = 5'h04,
      MODE_BURST = 5'h08,
      MODE_AUTORST = 5'h10
   } spwm_mode_t;

   typedef struct packed {
      logic aboveOn;
      logic belowOff;
      logic rampAboveFb;
      logic rampAboveSoft;
      logic aboveLimit;
      logic fault;
      logic burstReq;
      logic burstWake;
   } spwm_cmp_t;
endpackage : spwm_pkg

// *** hdl/spwm_ctrl.sv ***
// supply sequencing, oscillator, PWM latch, soft start and gate control
// assumes comparator outcomes arrive asynchronously and registers sit on AXI4-Lite
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
module spwm_ctrl #(
   parameter int unsigned SOFT_STEP_CYC = spwm_pkg::SOFT_STEP_CYC,
   parameter int unsigned SOFT_DONE_CYC = spwm_pkg::SOFT_DONE_CYC,
   parameter int unsigned JIT_PERIOD_CYC = spwm_pkg::JIT_PERIOD_CYC
) (
   input logic sys_clk,
   input logic nrst,
   input logic supplyAboveOn,
   input logic supplyBelowOff,
   input logic rampAboveFb,
   input logic rampAboveSoft,
   input logic csAboveLimit,
   input logic faultReq,
   input logic burstReq,
   input logic burstWake,
   output logic startupCellOn,
   output logic biasOn,
   output logic vrefOn,
   output logic gateDrive,
   output logic rampResetClosed,
   output logic softSinkOn,
   output logic [4:0] softStep,
   output logic jitterActive,
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready
);
   localparam logic [7:0] BASE = 8'(spwm_pkg::OSC_PERIOD_CYC);
   localparam logic [3:0] DEV = 4'(spwm_pkg::JIT_DEV_CYC);
   localparam logic [3:0] DEV2M1 = 4'(2 * spwm_pkg::JIT_DEV_CYC - 1);
   localparam logic [7:0] MIN_OFF = 8'(spwm_pkg::MIN_OFF_CYC);
   localparam logic [10:0] JIT_STEP_M1 =
      11'(JIT_PERIOD_CYC / (4 * spwm_pkg::JIT_DEV_CYC) - 1);
   localparam logic [12:0] STEP_M1 = 13'(SOFT_STEP_CYC - 1);
   localparam logic [17:0] DONE_M1 = 18'(SOFT_DONE_CYC - 1);
   localparam logic [4:0] STEP_MAX = 5'(spwm_pkg::SOFT_STEPS - 1);

   typedef struct packed {
      spwm_pkg::spwm_cmp_t s1;
      spwm_pkg::spwm_cmp_t s2;
      spwm_pkg::spwm_mode_t mode;
      logic [7:0] oscCnt;
      logic [7:0] period;
      logic [3:0] jitOff;
      logic jitUp;
      logic [10:0] jitTmr;
      logic [17:0] softTmr;
      logic [12:0] stepTmr;
      logic [4:0] softStep;
      logic latch;
      logic gate;
      logic ramp;
      logic startup;
      logic bias;
      logic vref;
      logic sink;
      logic jitAct;
      logic gateEn;
      logic jitEn;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [1:0] rResp;
      logic [31:0] rData;
   } spwm_reg_t;

   localparam spwm_reg_t REG_RST = '{
      mode: spwm_pkg::MODE_LOCKOUT,
      period: BASE,
      jitOff: DEV,
      jitUp: 1'h1,
      startup: 1'h1,
      ramp: 1'h1,
      gateEn: spwm_pkg::CTRL_GATE_RST,
      jitEn: spwm_pkg::CTRL_JIT_RST,
      default: '0
   };

   spwm_reg_t q;
   spwm_reg_t n;
   spwm_pkg::spwm_cmp_t c;
   logic restart;
   logic cut;
   logic trig;
   logic [7:0] onCyc;
   logic [31:0] statWord;

   assign c = q.s2;
   assign onCyc = 8'((16'(q.period) * 16'(spwm_pkg::DUTY_NUM)) / 16'(spwm_pkg::DUTY_DEN));
   assign statWord = 32'({q.jitAct, q.startup, q.bias, q.gate, q.latch, q.softStep, q.mode});

   always_comb begin
      n = q;
      restart = 1'b0;
      // first stage is read only by the second
      n.s1 = '{supplyAboveOn, supplyBelowOff, rampAboveFb, rampAboveSoft,
               csAboveLimit, faultReq, burstReq, burstWake};
      n.s2 = q.s1;

      unique case (q.mode)
         spwm_pkg::MODE_LOCKOUT: begin
            if (c.aboveOn) begin
               n.mode = spwm_pkg::MODE_SOFT;
               restart = 1'b1;
            end
         end
         spwm_pkg::MODE_SOFT: begin
            if (q.softTmr == DONE_M1) begin
               n.mode = spwm_pkg::MODE_NORMAL;
            end
         end
         spwm_pkg::MODE_NORMAL: begin
            if (c.burstReq) begin
               n.mode = spwm_pkg::MODE_BURST;
            end
         end
         spwm_pkg::MODE_BURST: begin
            if (!c.burstReq) begin
               n.mode = spwm_pkg::MODE_NORMAL;
            end
         end
         spwm_pkg::MODE_AUTORST: begin
            // fault gone: restart on its own, no line recycle needed
            if (!c.fault) begin
               n.mode = spwm_pkg::MODE_SOFT;
               restart = 1'b1;
            end
         end
      endcase
      if (q.mode != spwm_pkg::MODE_LOCKOUT && q.mode != spwm_pkg::MODE_AUTORST && c.fault) begin
         n.mode = spwm_pkg::MODE_AUTORST;
         restart = 1'b0;
      end
      // lockout hysteresis: the off threshold is only looked at once running
      if (q.mode != spwm_pkg::MODE_LOCKOUT && c.belowOff) begin
         n.mode = spwm_pkg::MODE_LOCKOUT;
         restart = 1'b0;
      end

      // soft start counter
      if (n.mode == spwm_pkg::MODE_LOCKOUT || n.mode == spwm_pkg::MODE_AUTORST || restart) begin
         n.softTmr = '0;
         n.stepTmr = '0;
         n.softStep = '0;
      end else if (q.mode == spwm_pkg::MODE_SOFT) begin
         n.softTmr = q.softTmr + 18'h00001;
         if (q.stepTmr == STEP_M1) begin
            n.stepTmr = '0;
            if (q.softStep != STEP_MAX) begin
               n.softStep = q.softStep + 5'h01;
            end
         end else begin
            n.stepTmr = q.stepTmr + 13'h0001;
         end
      end

      n.startup = n.mode == spwm_pkg::MODE_LOCKOUT;
      n.bias = n.mode == spwm_pkg::MODE_SOFT || n.mode == spwm_pkg::MODE_NORMAL ||
               (n.mode == spwm_pkg::MODE_BURST && c.burstWake);
      n.vref = n.mode != spwm_pkg::MODE_LOCKOUT && n.mode != spwm_pkg::MODE_AUTORST;
      n.sink = n.mode == spwm_pkg::MODE_SOFT;

      // frequency jitter, a triangle sweep of the period
      n.jitAct = n.mode == spwm_pkg::MODE_NORMAL && q.jitEn;
      if (!q.jitAct) begin
         n.jitOff = DEV;
         n.jitUp = 1'b1;
         n.jitTmr = '0;
      end else if (q.jitTmr == JIT_STEP_M1) begin
         n.jitTmr = '0;
         if (q.jitUp) begin
            n.jitOff = q.jitOff + 4'h1;
            n.jitUp = q.jitOff != DEV2M1;
         end else begin
            n.jitOff = q.jitOff - 4'h1;
            n.jitUp = q.jitOff == 4'h1;
         end
      end else begin
         n.jitTmr = q.jitTmr + 11'h001;
      end

      // oscillator; the period only changes at a wrap so no cycle is torn
      if (q.oscCnt >= q.period - 8'h01) begin
         n.oscCnt = '0;
         n.period = q.jitAct ? BASE - 8'(DEV) + 8'(q.jitOff) : BASE;
      end else begin
         n.oscCnt = q.oscCnt + 8'h01;
      end
      trig = n.oscCnt == 8'h00;

      // both comparator inputs see the same amplified sense plus ramp sum
      cut = c.rampAboveFb || (q.sink && c.rampAboveSoft) || c.aboveLimit;
      if (trig) begin
         n.latch = 1'b1;
      end else begin
         n.latch = q.latch && !cut && n.oscCnt < onCyc;
      end
      n.ramp = n.oscCnt >= onCyc;
      n.gate = n.latch && n.bias && q.gateEn &&
               n.oscCnt >= MIN_OFF &&
               n.oscCnt < onCyc;

      // register slave, write side
      if (q.bValid && s_axi_bready) begin
         n.bValid = 1'b0;
      end
      if (s_axi_awvalid && q.awReady) begin
         n.awHeld = 1'b1;
         n.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wReady) begin
         n.wHeld = 1'b1;
         n.wData = s_axi_wdata;
         n.wStrb = s_axi_wstrb;
      end
      if (q.awHeld && q.wHeld && !q.bValid) begin
         n.awHeld = 1'b0;
         n.wHeld = 1'b0;
         n.bValid = 1'b1;
         n.bResp = spwm_pkg::RESP_OKAY;
         if (q.awAddr[7:2] == spwm_pkg::CTRL_OFS[7:2]) begin
            if (q.wStrb[0]) begin
               n.gateEn = q.wData[spwm_pkg::CTRL_GATE_BIT];
               n.jitEn = q.wData[spwm_pkg::CTRL_JIT_BIT];
            end
         end else if (q.awAddr[7:2] != spwm_pkg::STAT_OFS[7:2] &&
                      q.awAddr[7:2] != spwm_pkg::PER_OFS[7:2]) begin
            n.bResp = spwm_pkg::RESP_SLVERR;
         end
      end
      n.awReady = !n.awHeld && !n.bValid;
      n.wReady = !n.wHeld && !n.bValid;

      // read side: data stand from the same edge that takes the address
      if (q.rValid && s_axi_rready) begin
         n.rValid = 1'b0;
      end
      if (s_axi_arvalid && q.arReady) begin
         n.rValid = 1'b1;
         n.rResp = spwm_pkg::RESP_OKAY;
         n.rData = '0;
         if (s_axi_araddr[7:2] == spwm_pkg::CTRL_OFS[7:2]) begin
            n.rData[spwm_pkg::CTRL_GATE_BIT] = q.gateEn;
            n.rData[spwm_pkg::CTRL_JIT_BIT] = q.jitEn;
         end else if (s_axi_araddr[7:2] == spwm_pkg::STAT_OFS[7:2]) begin
            n.rData = statWord;
         end else if (s_axi_araddr[7:2] == spwm_pkg::PER_OFS[7:2]) begin
            n.rData = 32'(q.period);
         end else begin
            n.rResp = spwm_pkg::RESP_SLVERR;
         end
      end
      n.arReady = !n.rValid;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         q <= REG_RST;
      end else begin
         q <= n;
      end
   end

   assign startupCellOn = q.startup;
   assign biasOn = q.bias;
   assign vrefOn = q.vref;
   assign gateDrive = q.gate;
   assign rampResetClosed = q.ramp;
   assign softSinkOn = q.sink;
   assign softStep = q.softStep;
   assign jitterActive = q.jitAct;
   assign s_axi_awready = q.awReady;
   assign s_axi_wready = q.wReady;
   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp = q.bResp;
   assign s_axi_arready = q.arReady;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rresp = q.rResp;
   assign s_axi_rdata = q.rData;

   property p_lock_on;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode == spwm_pkg::MODE_LOCKOUT && c.aboveOn |=>
         q.mode == spwm_pkg::MODE_SOFT && !q.startup && q.bias && q.softStep == 5'h00;
   endproperty
   a_lock_on: assert property (p_lock_on) else $error("turn-on sequence wrong");

   property p_turn_off;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode != spwm_pkg::MODE_LOCKOUT && c.belowOff |=>
         q.mode == spwm_pkg::MODE_LOCKOUT && !q.bias && q.softStep == 5'h00;
   endproperty
   a_turn_off: assert property (p_turn_off) else $error("turn-off did not clear");

   property p_hyst;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode == spwm_pkg::MODE_LOCKOUT && !c.aboveOn |=> q.mode == spwm_pkg::MODE_LOCKOUT;
   endproperty
   a_hyst: assert property (p_hyst) else $error("left lockout below turn-on");

   property p_autorst;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode == spwm_pkg::MODE_AUTORST |-> !q.bias && !q.gate && q.softStep == 5'h00;
   endproperty
   a_autorst: assert property (p_autorst) else $error("bias on in auto restart");

   property p_burst;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode == spwm_pkg::MODE_BURST |-> q.vref && (q.bias == $past(q.s2.burstWake));
   endproperty
   a_burst: assert property (p_burst) else $error("burst bias or reference wrong");

   property p_pwm_cut;
      @(posedge sys_clk) disable iff (!nrst)
      q.latch && (c.rampAboveFb || c.aboveLimit) |=> !q.gate;
   endproperty
   a_pwm_cut: assert property (p_pwm_cut) else $error("gate survived comparator reset");

   property p_min_off;
      @(posedge sys_clk) disable iff (!nrst)
      q.oscCnt == 8'h00 |-> !q.gate ##1 !q.gate;
   endproperty
   a_min_off: assert property (p_min_off) else $error("gate on in minimum off time");

   property p_max_duty;
      @(posedge sys_clk) disable iff (!nrst)
      q.oscCnt >= onCyc |-> !q.gate && q.ramp;
   endproperty
   a_max_duty: assert property (p_max_duty) else $error("gate on past maximum duty");

   property p_soft_step;
      @(posedge sys_clk) disable iff (!nrst)
      $past(q.mode) == spwm_pkg::MODE_SOFT && q.mode == spwm_pkg::MODE_SOFT &&
         q.softStep != $past(q.softStep) |-> q.softStep == $past(q.softStep) + 5'h01;
   endproperty
   a_soft_step: assert property (p_soft_step) else $error("soft step not by one");

   property p_jit_gate;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode != spwm_pkg::MODE_NORMAL |-> !q.jitAct;
   endproperty
   a_jit_gate: assert property (p_jit_gate) else $error("jitter outside normal mode");

   property p_lock_gate;
      @(posedge sys_clk) disable iff (!nrst)
      q.mode == spwm_pkg::MODE_LOCKOUT |-> !q.gate && q.startup;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("gate high in lockout");
endmodule : spwm_ctrl

// *** tb/spwm_stage_model.sv ***
// power stage stand-in: sensed current ramp and comparator outcomes seen by the controller
// assumes gateDrive high means the switch conducts; the bench picks which comparator trips
module spwm_stage_model (
   input wire logic sys_clk,
   input wire logic gateDrive,
   input wire logic [7:0] onCyc,
   input wire logic [1:0] cutSel,
   output logic rampAboveFb,
   output logic rampAboveSoft,
   output logic csAboveLimit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] onCnt_q = 8'h00;
   logic hit;
   always_ff @(posedge sys_clk) begin
      onCnt_q <= gateDrive ? onCnt_q + 8'h01 : 8'h00;
   end
   // the ramp collapses when the switch opens, so every trip line drops with the gate
   assign hit = gateDrive && (onCnt_q >= onCyc);
   assign rampAboveFb = hit && (cutSel == 2'h0);
   assign csAboveLimit = hit && (cutSel == 2'h1);
   assign rampAboveSoft = hit && (cutSel == 2'h2);
endmodule : spwm_stage_model

// *** tb/smps_pwm_softstart_ctrl_tb.sv ***
// self-checking bench for the supply sequencing and PWM control block
// assumes short soft start counts via parameters; AXI4-Lite master driven on rising edges
module smps_pwm_softstart_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SSTEP = 20;
   localparam int SDONE = 700;
   logic sys_clk, nrst, supplyAboveOn, supplyBelowOff, faultReq, burstReq, burstWake;
   logic rampAboveFb, rampAboveSoft, csAboveLimit;
   logic startupCellOn, biasOn, vrefOn, gateDrive, rampResetClosed, softSinkOn, jitterActive;
   logic [4:0] softStep, lastStep;
   logic [7:0] s_axi_awaddr, s_axi_araddr, onCyc;
   logic [1:0] cutSel, s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int failures = 0, checked = 0, cyc = 0, sRise = 0, lastChg = 0;
   int dly, hi, per, pMin, pMax;
   bit inSoft = 0;

   spwm_ctrl #(.SOFT_STEP_CYC(SSTEP), .SOFT_DONE_CYC(SDONE), .JIT_PERIOD_CYC(240)) dut_u (
      .sys_clk(sys_clk), .nrst(nrst), .supplyAboveOn(supplyAboveOn),
      .supplyBelowOff(supplyBelowOff), .rampAboveFb(rampAboveFb), .rampAboveSoft(rampAboveSoft),
      .csAboveLimit(csAboveLimit), .faultReq(faultReq), .burstReq(burstReq),
      .burstWake(burstWake), .startupCellOn(startupCellOn), .biasOn(biasOn), .vrefOn(vrefOn),
      .gateDrive(gateDrive), .rampResetClosed(rampResetClosed), .softSinkOn(softSinkOn),
      .softStep(softStep), .jitterActive(jitterActive), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   spwm_stage_model stage_u (.sys_clk(sys_clk), .gateDrive(gateDrive), .onCyc(onCyc),
      .cutSel(cutSel), .rampAboveFb(rampAboveFb), .rampAboveSoft(rampAboveSoft),
      .csAboveLimit(csAboveLimit));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   function automatic int maxOn();
      return spwm_pkg::OSC_PERIOD_CYC * spwm_pkg::DUTY_NUM / spwm_pkg::DUTY_DEN;
   endfunction : maxOn

   task automatic stop_test;
      if (failures == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input bit ok, input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (!ok) begin
         failures++;
         $display("Error %s expected %0h seen %0h", nm, e, s);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wt

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
      if (n >= 100) begin
         chk(0, "writeTimeout", 32'h1, 32'h0);
         stop_test;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      if (n >= 100) begin
         chk(0, "readTimeout", 32'h1, 32'h0);
         stop_test;
      end
   endtask : rd

   task automatic chkMode(input logic [4:0] m);
      rd(spwm_pkg::STAT_OFS, d, r);
      chk(d[4:0] === m && r === spwm_pkg::RESP_OKAY, "mode", {27'h0, m}, d);
      chk(d[spwm_pkg::ST_START_BIT] === (m == spwm_pkg::MODE_LOCKOUT) &&
         d[spwm_pkg::ST_JIT_BIT] === (m == spwm_pkg::MODE_NORMAL), "statFlags", {27'h0, m}, d);
   endtask : chkMode

   task automatic noGate(input int n);
      int h;
      h = 0;
      repeat (n) begin
         @(negedge sys_clk);
         if (gateDrive !== 1'b0) h++;
      end
      chk(h == 0, "gateHeldLow", 32'h0, h);
   endtask : noGate

   // one oscillator period, entered and left just after the ramp switch opens
   task automatic gatePulse;
      dly = 0;
      hi = 0;
      per = 0;
      while (gateDrive !== 1'b1 && per < 400) begin wt(1); dly++; per++; end
      while (gateDrive === 1'b1 && per < 400) begin wt(1); hi++; per++; end
      while (rampResetClosed !== 1'b1 && per < 400) begin wt(1); per++; end
      while (rampResetClosed === 1'b1 && per < 400) begin wt(1); per++; end
      if (per >= 400) begin
         chk(0, "gateTimeout", 32'h1, 32'h0);
         stop_test;
      end
   endtask : gatePulse

   task automatic syncRamp;
      per = 0;
      while (rampResetClosed !== 1'b1 && per < 400) begin wt(1); per++; end
      gatePulse;
   endtask : syncRamp

   task automatic softEnd;
      int n;
      n = 0;
      while (softSinkOn === 1'b1 && n < 2 * SDONE) begin wt(1); n++; end
      wt(4);
      chk(softSinkOn === 1'b0 && jitterActive === 1'b1, "softEnd", 32'h1,
         jitterActive);
   endtask : softEnd

   // soft start step pacing watched whenever the sink runs, total length when bias stays on at its end
   always @(negedge sys_clk) begin
      cyc++;
      if (softSinkOn === 1'b1) begin
         if (!inSoft) begin inSoft = 1; sRise = cyc; lastChg = 0; end
         if (softStep !== lastStep && softStep !== 5'h00) begin
            if (lastChg != 0) chk(softStep === lastStep + 5'h01 && cyc - lastChg == SSTEP,
               "softStepPace", SSTEP, cyc - lastChg);
            lastChg = cyc;
         end
      end else if (inSoft) begin
         inSoft = 0;
         if (biasOn === 1'b1) begin
            chk(lastStep === 5'h1F, "softStepLast", 32'h1F, lastStep);
            chk(cyc - sRise >= SDONE - 1 && cyc - sRise <= SDONE + 1, "softLen", SDONE,
               cyc - sRise);
         end
      end
      lastStep = softStep;
   end

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial begin
      nrst = 1'b0; supplyAboveOn = 1'b0; supplyBelowOff = 1'b1; faultReq = 1'b0;
      burstReq = 1'b0; burstWake = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      cutSel = 2'h0; onCyc = 8'h00; seed = 32'h86F4; lastStep = 5'h00;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      wt(2);
      chk(startupCellOn === 1'b1 && biasOn === 1'b0, "lockoutOut", 32'h1, biasOn);
      rd(spwm_pkg::CTRL_OFS, d, r);
      chk(d === 32'h3 && r === spwm_pkg::RESP_OKAY, "ctrlReset", 32'h3, d);
      rd(8'h0C, d, r);
      chk(d === 32'h0 && r === spwm_pkg::RESP_SLVERR, "unmappedRd", 32'h0, {r, d[29:0]});
      wr(spwm_pkg::STAT_OFS, 32'hFFFFFFFF, r);
      chk(r === spwm_pkg::RESP_OKAY, "roWrite", spwm_pkg::RESP_OKAY, r);
      wr(8'h10, 32'h0, r);
      chk(r === spwm_pkg::RESP_SLVERR, "unmappedWr", spwm_pkg::RESP_SLVERR, r);
      chkMode(spwm_pkg::MODE_LOCKOUT);
      noGate(200);
      chk(startupCellOn === 1'b1 && biasOn === 1'b0, "belowOffLockout", 32'h1, biasOn);
      @(posedge sys_clk);
      supplyBelowOff <= 1'b0;
      supplyAboveOn <= 1'b1;
      wt(4);
      chk(biasOn === 1'b1 && startupCellOn === 1'b0, "turnOn", 32'h1, startupCellOn);
      chk(softSinkOn === 1'b1 && softStep === 5'h00 && jitterActive === 1'b0, "softBegin",
         32'h1, softStep);
      chkMode(spwm_pkg::MODE_SOFT);
      rd(spwm_pkg::PER_OFS, d, r);
      chk(d[7:0] === 8'(spwm_pkg::OSC_PERIOD_CYC), "period", spwm_pkg::OSC_PERIOD_CYC, d);
      cutSel = 2'h3;
      syncRamp;
      gatePulse;
      chk(dly == spwm_pkg::MIN_OFF_CYC, "minOff", spwm_pkg::MIN_OFF_CYC, dly);
      chk(dly + hi == maxOn(), "maxDuty", maxOn(), dly + hi);
      chk(per == spwm_pkg::OSC_PERIOD_CYC, "nomPeriod", spwm_pkg::OSC_PERIOD_CYC, per);
      cutSel = 2'h2;
      onCyc = 8'h10;
      gatePulse;
      chk(hi >= 18 && hi <= 20, "softCut", 32'd19, hi);
      softEnd;
      chkMode(spwm_pkg::MODE_NORMAL);
      syncRamp;
      pMin = 999;
      pMax = 0;
      repeat (8) begin
         seed = lfsr(seed);
         cutSel = {1'b0, seed[0]};
         onCyc = {2'h0, seed[6:1]} + 8'h04;
         gatePulse;
         chk(hi >= onCyc + 2 && hi <= onCyc + 4, "cmpCut", onCyc + 3, hi);
         if (per < pMin) pMin = per;
         if (per > pMax) pMax = per;
      end
      chk(pMin >= spwm_pkg::OSC_PERIOD_CYC - spwm_pkg::JIT_DEV_CYC && pMin != pMax
         && pMax <= spwm_pkg::OSC_PERIOD_CYC + spwm_pkg::JIT_DEV_CYC, "jitter", pMin, pMax);
      wr(spwm_pkg::CTRL_OFS, 32'h1, r);
      cutSel = 2'h3;
      syncRamp;
      gatePulse;
      chk(per == spwm_pkg::OSC_PERIOD_CYC, "jitterOff", spwm_pkg::OSC_PERIOD_CYC, per);
      wr(spwm_pkg::CTRL_OFS, 32'h0, r);
      noGate(200);
      wr(spwm_pkg::CTRL_OFS, 32'h3, r);
      @(posedge sys_clk);
      burstReq <= 1'b1;
      wt(4);
      chk(biasOn === 1'b0 && vrefOn === 1'b1 && startupCellOn === 1'b0, "burstIdle", 32'h1,
         biasOn);
      chkMode(spwm_pkg::MODE_BURST);
      @(posedge sys_clk);
      burstWake <= 1'b1;
      wt(4);
      chk(biasOn === 1'b1 && vrefOn === 1'b1, "burstWake", 32'h1, biasOn);
      @(posedge sys_clk);
      faultReq <= 1'b1;
      wt(4);
      chk(biasOn === 1'b0 && vrefOn === 1'b0, "autoRestart", 32'h0, biasOn);
      chkMode(spwm_pkg::MODE_AUTORST);
      noGate(160);
      @(posedge sys_clk);
      faultReq <= 1'b0;
      burstReq <= 1'b0;
      burstWake <= 1'b0;
      wt(4);
      chk(biasOn === 1'b1 && softSinkOn === 1'b1 && softStep === 5'h00, "restartSoft", 32'h1,
         softStep);
      softEnd;
      @(posedge sys_clk);
      supplyAboveOn <= 1'b0;
      supplyBelowOff <= 1'b1;
      wt(4);
      chk(biasOn === 1'b0 && startupCellOn === 1'b1 && gateDrive === 1'b0 && softStep === 5'h00,
         "turnOff", 32'h0, biasOn);
      chkMode(spwm_pkg::MODE_LOCKOUT);
      @(posedge sys_clk);
      supplyBelowOff <= 1'b0;
      supplyAboveOn <= 1'b1;
      wt(4);
      chk(softSinkOn === 1'b1 && softStep === 5'h00, "restartZero", 32'h0, softStep);
      stop_test;
   end
endmodule : smps_pwm_softstart_ctrl_tb
